// file: src/table_travel_record_control.v
// Table travel record positioning control and status logic.
// Notes on behaviour
// - Mode is table travel only when mode select holds ff (minus one).
// - Command bit 4 clear runs one block, set runs a sequence.
// - Command bit 6 set starts from the last active block.
// - Halt bit 8 stops the axle by ramp; clearing it resumes the block.
// - Rising edge of bit 9 starts; bit 9 low stops the axle by ramp.
// - Select field bits 11 to 15 gives start block n plus one.
// - Block number is computed from the field only at bit 9 rising.
// - State bit 8 is one while running; single block clears on completion.
// - Sequence clears bit 8 when next setting is 0, -1, -2 or -3.
// - Current block register follows the block being processed.
// - Master restarts an interrupted block with resume and a new start edge.
// - Resume without a valid block falls back to the select field.
// - Resumable register holds the block, or -1 if none or not interrupted.
// - Target reached sets when a positioning block enters the position window.
// - Under halt target reached is zero while decelerating, one at standstill.
// - Halt keeps the drive operation-enabled.
// - State bit 12 is one only when the gear is used and coupled.
`timescale 1ns/100ps
`include "travel_record_defines.vh"
module table_travel_record_control
(
  input  wire        clock_in,
  input  wire        rst_b_in,
  input  wire        obj_write_in,
  input  wire [15:0] obj_index_in,
  input  wire [15:0] obj_wdata_in,
  output reg  [15:0] obj_rdata_out,
  input  wire        op_enabled_in,
  input  wire        block_done_in,
  input  wire [7:0]  next_setting_in,
  input  wire        block_positioning_in,
  input  wire        in_position_window_in,
  input  wire        velocity_zero_in,
  input  wire        gear_used_in,
  input  wire        gear_coupled_in,
  input  wire        follow_over_window_in,
  input  wire [7:0]  drive_state_bits_in,
  output wire        motion_run_out,
  output wire        ramp_stop_out,
  output wire [15:0] target_block_out,
  output wire        block_load_out,
  output wire        mode_active_out
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_STOP = 3'b100;

  reg  [15:0] command_q;
  reg  [7:0]  mode_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         start_prev_q;
  reg         sequence_q;
  reg  [15:0] current_q;
  reg  [15:0] current_d;
  reg  [15:0] resumable_q;
  reg  [15:0] resumable_d;
  reg         target_q;
  reg         load_q;
  wire        table_mode;
  wire        start_bit;
  wire        halt_bit;
  wire        start_rise;
  wire        seq_end;
  wire        finished;
  wire [15:0] start_block;
  wire        follow_error;
  wire [15:0] state_word;

  assign table_mode = (mode_q == `MODE_TABLE_TRAVEL);
  assign start_bit  = table_mode && command_q[`CMD_START_BIT];
  assign halt_bit   = command_q[`CMD_HALT_BIT];
  assign start_rise = start_bit && !start_prev_q && op_enabled_in;
  assign seq_end    = (next_setting_in == `NEXT_END) || (next_setting_in == `NEXT_ERROR) ||
                      (next_setting_in == `NEXT_STOP_ERROR) ||
                      (next_setting_in == `NEXT_QSTOP_ERROR);
  assign finished   = block_done_in && (!sequence_q || seq_end);

  block_select_calc u_select
  (
    .select_in       (command_q[15:`CMD_SELECT_LSB]),
    .resume_in       (command_q[`CMD_RESUME_BIT]),
    .resumable_in    (resumable_q),
    .start_block_out (start_block)
  );

  follow_error_timer u_follow
  (
    .clock_in         (clock_in),
    .rst_b_in         (rst_b_in),
    .over_window_in   (follow_over_window_in),
    .follow_error_out (follow_error)
  );

  always @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      command_q <= `RST_COMMAND_WORD;
      mode_q    <= `RST_MODE_SELECT;
    end
    else if (obj_write_in)
    begin
      if (obj_index_in == `IDX_COMMAND_WORD)
        command_q <= obj_wdata_in;
      if (obj_index_in == `IDX_MODE_SELECT)
        mode_q <= obj_wdata_in[7:0];
    end
  end

  always @*
  begin
    state_d     = state_q;
    current_d   = current_q;
    resumable_d = resumable_q;
    case (state_q)
      ST_IDLE:
      begin
        if (start_rise)
        begin
          state_d   = ST_RUN;
          current_d = start_block;
        end
      end
      ST_RUN:
      begin
        if (!start_bit || !op_enabled_in)
        begin
          state_d     = ST_STOP;
          resumable_d = current_q;
        end
        else if (finished)
        begin
          state_d     = ST_IDLE;
          current_d   = `RST_BLOCK_NUMBER;
          resumable_d = `NO_RESUME_BLOCK;
        end
        else if (block_done_in)
          current_d = {8'h00, next_setting_in};
      end
      ST_STOP:
      begin
        // A new start edge during the ramp-down must not be lost.
        if (start_rise)
        begin
          state_d   = ST_RUN;
          current_d = start_block;
        end
        else
        begin
          current_d = `RST_BLOCK_NUMBER;
          if (velocity_zero_in || !op_enabled_in)
            state_d = ST_IDLE;
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      state_q      <= ST_IDLE;
      start_prev_q <= 1'b0;
      sequence_q   <= 1'b0;
      current_q    <= `RST_BLOCK_NUMBER;
      resumable_q  <= `NO_RESUME_BLOCK;
      target_q     <= 1'b0;
      load_q       <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      start_prev_q <= start_bit;
      current_q    <= current_d;
      resumable_q  <= resumable_d;
      load_q       <= (current_d != current_q) && (state_d == ST_RUN);
      if (start_rise)
        sequence_q <= command_q[`CMD_SEQUENCE_BIT];
      if (halt_bit)
        target_q <= velocity_zero_in;
      else if (state_d == ST_RUN && current_d != current_q)
        target_q <= 1'b0;
      else if (block_positioning_in)
        target_q <= in_position_window_in;
    end
  end

  // Halt only ramps the axle; the power state is left to the drive.
  assign motion_run_out   = (state_q == ST_RUN) && !halt_bit;
  assign ramp_stop_out    = (state_q == ST_STOP) || (state_q == ST_RUN && halt_bit);
  assign target_block_out = current_q;
  assign block_load_out   = load_q;
  assign mode_active_out  = table_mode;

  assign state_word = {2'b00, follow_error,
                       gear_used_in && gear_coupled_in,
                       1'b0, target_q, 1'b0,
                       state_q == ST_RUN,
                       drive_state_bits_in};

  always @*
  begin
    case (obj_index_in)
      `IDX_CURRENT_BLOCK:   obj_rdata_out = current_q;
      `IDX_RESUMABLE_BLOCK: obj_rdata_out = resumable_q;
      `IDX_COMMAND_WORD:    obj_rdata_out = command_q;
      `IDX_STATE_WORD:      obj_rdata_out = state_word;
      `IDX_MODE_SELECT:     obj_rdata_out = {8'h00, mode_q};
      default:              obj_rdata_out = 16'h0000;
    endcase
  end
endmodule // table_travel_record_control

// file: src/travel_record_defines.vh
// Constants for the table travel record control logic.
`ifndef TRAVEL_RECORD_DEFINES_VH
`define TRAVEL_RECORD_DEFINES_VH
`define IDX_CURRENT_BLOCK      16'h5ff0
`define IDX_RESUMABLE_BLOCK    16'h5ff1
`define IDX_COMMAND_WORD       16'h6040
`define IDX_STATE_WORD         16'h6041
`define IDX_MODE_SELECT        16'h6060
`define MODE_TABLE_TRAVEL      8'hff
`define CMD_SEQUENCE_BIT       4
`define CMD_RESUME_BIT         6
`define CMD_HALT_BIT           8
`define CMD_START_BIT          9
`define CMD_SELECT_LSB         11
`define STS_IN_PROGRESS_BIT    8
`define STS_TARGET_BIT         10
`define STS_IN_GEAR_BIT        12
`define STS_FOLLOW_ERR_BIT     13
`define RST_COMMAND_WORD       16'h0000
`define RST_MODE_SELECT        8'h00
`define RST_BLOCK_NUMBER       16'h0000
`define NO_RESUME_BLOCK        16'hffff
`define NEXT_END               8'h00
`define NEXT_ERROR             8'hff
`define NEXT_STOP_ERROR        8'hfe
`define NEXT_QSTOP_ERROR       8'hfd
`define FOLLOW_TIME_NS         1000
`define CLOCK_PERIOD_NS        5
`define FOLLOW_CYCLES          16'd200
`endif

// file: src/block_select_calc.v
// Start block calculation from the select field or the resumable block.
`timescale 1ns/100ps
`include "travel_record_defines.vh"
module block_select_calc
(
  input  wire [4:0]  select_in,
  input  wire        resume_in,
  input  wire [15:0] resumable_in,
  output wire [15:0] start_block_out
);
  wire [15:0] selected_block;
  wire        resume_valid;

  assign selected_block  = {11'h000, select_in} + 16'h0001;
  assign resume_valid    = (resumable_in != `NO_RESUME_BLOCK);
  // Resume falls back to the select field when nothing is resumable.
  assign start_block_out = (resume_in && resume_valid) ? resumable_in : selected_block;
endmodule // block_select_calc

// file: src/follow_error_timer.v
// Following error detection with a minimum persistence time.
`timescale 1ns/100ps
`include "travel_record_defines.vh"
module follow_error_timer
(
  input  wire clock_in,
  input  wire rst_b_in,
  input  wire over_window_in,
  output wire follow_error_out
);
  reg [15:0] count_q;
  reg        error_q;

  always @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      count_q <= 16'h0000;
      error_q <= 1'b0;
    end
    else if (!over_window_in)
    begin
      count_q <= 16'h0000;
      error_q <= 1'b0;
    end
    else if (count_q >= `FOLLOW_CYCLES)
      error_q <= 1'b1;
    else
      count_q <= count_q + 16'h0001;
  end

  assign follow_error_out = error_q;
endmodule // follow_error_timer

// file: sim/motion_engine_model.sv
// Motion engine stand-in that finishes blocks, chains a sequence and ramps the axle down.
`timescale 1ns/100ps
module motion_engine_model #(parameter int RUN_CYCLES = 20)
(
  input  wire logic        clock_in,
  input  wire logic        run_in,
  input  wire logic [15:0] block_in,
  output logic             done_out,
  output logic [7:0]       next_out,
  output logic             still_out
);
  int cnt_q = 0;
  int idle_q = 0;
  // Blocks 4 and 5 chain onward, any other block ends the sequence.
  assign next_out = (block_in == 16'h0004 || block_in == 16'h0005) ? block_in[7:0] + 8'h01 : 8'h00;
  assign done_out = run_in && cnt_q == RUN_CYCLES;
  // The axle needs a few idle cycles to ramp down to standstill.
  assign still_out = idle_q >= 3;
  always @(posedge clock_in)
  begin
    cnt_q <= (run_in && !done_out) ? cnt_q + 1 : 0;
    idle_q <= run_in ? 0 : idle_q + 1;
  end
endmodule // motion_engine_model

// file: sim/table_travel_record_control_chk.sv
// Port checker for the table travel record control block.
`timescale 1ns/100ps
module ttr_chk
(
  input wire logic        clock_in,
  input wire logic        rst_b_in,
  input wire logic        obj_write_in,
  input wire logic [15:0] obj_index_in,
  input wire logic [15:0] obj_wdata_in,
  input wire logic [15:0] obj_rdata_out,
  input wire logic        op_enabled_in,
  input wire logic        block_done_in,
  input wire logic [7:0]  next_setting_in,
  input wire logic        velocity_zero_in,
  input wire logic        gear_used_in,
  input wire logic        gear_coupled_in,
  input wire logic        motion_run_out,
  input wire logic        ramp_stop_out,
  input wire logic [15:0] target_block_out,
  input wire logic        mode_active_out,
  input wire logic        block_load_out
);
  logic [15:0] cmd_q;
  logic [7:0]  nx_q;
  wire cw = obj_write_in && obj_index_in == 16'h6040;
  wire mf = obj_wdata_in[7:0] == 8'hff;
  wire nend = next_setting_in == 8'h00 || next_setting_in >= 8'hfd;
  wire go = cw && obj_wdata_in[9] && !obj_wdata_in[8] && !cmd_q[9] && mode_active_out
            && op_enabled_in && velocity_zero_in;
  wire fin = block_done_in && motion_run_out;
  always @(posedge clock_in)
  begin
    cmd_q <= !rst_b_in ? 16'h0000 : cw ? obj_wdata_in : cmd_q;
    nx_q <= block_done_in ? next_setting_in : nx_q;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  a_mode_flag: assert property (obj_write_in && obj_index_in == 16'h6060
    |=> mode_active_out == $past(mf)) else $error("mode flag");
  a_start_run: assert property (go |-> ##2 motion_run_out && block_load_out)
    else $error("start");
  a_select_block: assert property (go && !obj_wdata_in[6] |-> ##2
    target_block_out == {11'h000, cmd_q[15:11]} + 16'h0001) else $error("select");
  a_halt_hold: assert property (cmd_q[8] && $past(cmd_q[8]) |-> !motion_run_out)
    else $error("halt");
  a_stop_drop: assert property (cw && !obj_wdata_in[9] |-> ##2 !motion_run_out)
    else $error("stop");
  a_single_end: assert property (fin && !cmd_q[4] |=> !motion_run_out)
    else $error("single end");
  a_seq_end: assert property (fin && cmd_q[4] && nend |=> !motion_run_out)
    else $error("seq end");
  a_seq_next: assert property (fin && cmd_q[4] && !nend
    |-> ##[1:2] target_block_out == {8'h00, nx_q}) else $error("seq next");
  a_gear_bit: assert property (obj_index_in == 16'h6041 && $stable(gear_used_in)
    && $stable(gear_coupled_in) |-> obj_rdata_out[12] == (gear_used_in && gear_coupled_in))
    else $error("gear");
  c_start: cover property (go);
  c_chain: cover property (fin && cmd_q[4] && !nend);
  c_ramp: cover property (ramp_stop_out);
endmodule // ttr_chk
bind table_travel_record_control ttr_chk ttr_chk_inst (.*);

// file: sim/tb.sv
// Self-checking bench for the table travel record control block.
`timescale 1ns/100ps
module tb;
  logic clock_in = 1'b0, rst_b_in = 1'b0, obj_write_in = 1'b0, op_enabled_in = 1'b1;
  logic [15:0] obj_index_in = 16'h0000, obj_wdata_in = 16'h0000, obj_rdata_out, target_block_out;
  logic block_positioning_in = 1'b1, in_position_window_in = 1'b1, velocity_zero_in;
  logic gear_used_in = 1'b0, gear_coupled_in = 1'b0, follow_over_window_in = 1'b0;
  logic [7:0] drive_state_bits_in = 8'h37, next_setting_in;
  logic block_done_in, motion_run_out, ramp_stop_out, block_load_out, mode_active_out;
  logic [4:0] sel [4] = '{5'h00, 5'h03, 5'h10, 5'h1f};
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  table_travel_record_control table_travel_record_control_inst (.*);
  motion_engine_model motion_engine_model_inst (.clock_in(clock_in), .run_in(motion_run_out),
    .block_in(target_block_out), .done_out(block_done_in), .next_out(next_setting_in),
    .still_out(velocity_zero_in));
  initial
  begin
    forever #2.5 clock_in = ~clock_in;
  end
  task automatic stop_test();
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      stop_test();
    end
  end
  task automatic ck(input string n, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wr(input logic [15:0] i, input logic [15:0] d);
    @(posedge clock_in);
    obj_write_in <= 1'b1;
    obj_index_in <= i;
    obj_wdata_in <= d;
    @(posedge clock_in);
    obj_write_in <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] i, input logic [15:0] m, input logic [15:0] e);
    @(posedge clock_in);
    obj_index_in <= i;
    #1 ck("obj", e, obj_rdata_out & m);
  endtask
  initial
  begin
    repeat (5) @(posedge clock_in);
    rst_b_in <= 1'b1;
    rdc(16'h6040, 16'hffff, 16'h0000);
    rdc(16'h5ff1, 16'hffff, 16'hffff);
    rdc(16'h1234, 16'hffff, 16'h0000);
    wr(16'h6040, 16'h0006);
    wr(16'h6040, 16'h0007);
    wr(16'h6040, 16'h020f);
    tk(3);
    ck("run", 16'h0000, 16'(motion_run_out));
    wr(16'h6040, 16'h0007);
    wr(16'h6060, 16'h00ff);
    wr(16'h6040, 16'h000f);
    for (int n = 0; n < 4; n++)
    begin
      wr(16'h6040, {sel[n], 11'h20f});
      tk(2);
      ck("run", 16'h0001, 16'(motion_run_out));
      ck("blk", {11'h000, sel[n]} + 16'h0001, target_block_out);
      rdc(16'h6041, 16'h0100, 16'h0100);
      tk(25);
      rdc(16'h6041, 16'h0500, 16'h0400);
      rdc(16'h5ff1, 16'hffff, 16'hffff);
      wr(16'h6040, 16'h000f);
    end
    wr(16'h6040, 16'h1a1f);
    tk(32);
    ck("blk", 16'h0005, target_block_out);
    wr(16'h6040, 16'h181f);
    tk(2);
    ck("run", 16'h0000, 16'(motion_run_out));
    rdc(16'h5ff1, 16'hffff, 16'h0005);
    tk(5);
    wr(16'h6040, 16'h005f);
    wr(16'h6040, 16'h025f);
    tk(2);
    ck("blk", 16'h0005, target_block_out);
    tk(60);
    ck("run", 16'h0000, 16'(motion_run_out));
    rdc(16'h5ff0, 16'hffff, 16'h0000);
    rdc(16'h5ff1, 16'hffff, 16'hffff);
    wr(16'h6040, 16'h104f);
    in_position_window_in <= 1'b0;
    wr(16'h6040, 16'h124f);
    tk(2);
    ck("blk", 16'h0003, target_block_out);
    wr(16'h6040, 16'h134f);
    tk(1);
    ck("stop", 16'h0001, 16'(ramp_stop_out));
    rdc(16'h6041, 16'h0400, 16'h0000);
    tk(5);
    rdc(16'h6041, 16'h04ff, 16'h0437);
    wr(16'h6040, 16'h124f);
    tk(2);
    ck("run", 16'h0001, 16'(motion_run_out));
    for (int g = 0; g < 4; g++)
    begin
      @(posedge clock_in);
      gear_used_in <= g[0];
      gear_coupled_in <= g[1];
      rdc(16'h6041, 16'h1000, (g == 3) ? 16'h1000 : 16'h0000);
    end
    @(posedge clock_in);
    follow_over_window_in <= 1'b1;
    tk(150);
    rdc(16'h6041, 16'h2000, 16'h0000);
    tk(60);
    rdc(16'h6041, 16'h2000, 16'h2000);
    stop_test();
  end
endmodule // tb
